/* logic/pha_target.sv */
module pha_target #(
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_reset,
    pha_bus_if.targ bus,
    output logic [31:0] o_wr_data,
    output logic o_wr_valid,
    input wire logic i_wr_ready,
    input wire logic [31:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_rd_ready,
    output logic o_cfg_hit,
    output logic o_par_err
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DATA = 3'b001,
        ST_TURN = 3'b011,
        ST_BUSY = 3'b010
    } pha_tstate_t;

    typedef struct packed {
        pha_tstate_t st;
        logic write;
        logic stop_after;
        logic [1:0][31:0] buf_d;
        logic [1:0] buf_v;
        logic wptr;
        logic rptr;
        logic [31:0] t_ad;
        logic t_ad_oe;
        logic t_par;
        logic t_par_oe;
        logic trdy_n;
        logic stop_n;
        logic devsel_n;
        logic ctl_oe;
        logic chk_p1;
        logic [31:0] chk_ad;
        logic [3:0] chk_cbe;
        logic perr_n;
        logic perr_oe;
        logic serr_n;
        logic claimed_done;
        logic special;
        logic cfg_hit;
        logic par_err;
        logic [31:0] wr_data;
        logic wr_valid;
        logic rd_ready;
        logic addr_chk;
        logic [31:0] addr_ad;
        logic [3:0] addr_cbe;
    } pha_tregs_t;

    pha_tregs_t q, d;
    logic xfer;
    logic addr_phase;
    logic hit;
    logic [3:0] cmd;
    logic bad_data;

    always_comb
    begin
        d = q;
        cmd = bus.m_cbe;
        addr_phase = (q.st == ST_IDLE) && !bus.m_frame_n && bus.m_ad_oe;
        // config needs idsel; memory decodes the upper address bits
        hit = 1'b0;
        if ((cmd == pha_pkg::CMD_CFG_RD || cmd == pha_pkg::CMD_CFG_WR)
            && bus.m_idsel)
            hit = 1'b1;
        else if ((cmd == pha_pkg::CMD_MEM_RD || cmd == pha_pkg::CMD_MEM_WR)
            && bus.m_ad[31:pha_pkg::BAR_BITS]
               == pha_pkg::BAR_BASE[31:pha_pkg::BAR_BITS])
            hit = 1'b1;
        xfer = (q.st == ST_DATA) && !bus.m_irdy_n && !q.trdy_n;
        bad_data = 1'b0;
        d.chk_p1 = 1'b0;
        d.addr_chk = addr_phase;
        if (addr_phase)
        begin
            d.addr_ad = bus.m_ad;
            d.addr_cbe = bus.m_cbe;
        end
        d.par_err = 1'b0;
        d.serr_n = 1'b1;
        // address parity arrives one clock after address phase
        if (q.addr_chk && bus.m_par_oe
            && pha_pkg::pha_parity(q.addr_ad, q.addr_cbe) != bus.m_par)
            d.serr_n = 1'b0;
        // write data parity: check a clock after transfer, report next
        if (q.chk_p1 && bus.m_par_oe)
            bad_data = pha_pkg::pha_parity(q.chk_ad, q.chk_cbe)
                != bus.m_par;
        // driven at once so it is sampled two clocks after the data phase
        d.par_err = bad_data && q.claimed_done && !q.special;
        if (d.par_err)
        begin
            d.perr_n = 1'b0;
            d.perr_oe = 1'b1;
        end
        else if (q.perr_oe && !q.perr_n)
            d.perr_n = 1'b1;
        else
            d.perr_oe = 1'b0;
        // read-data parity, driven a clock after data
        d.t_par = pha_pkg::pha_parity(q.t_ad, pha_pkg::BE_ALL);
        d.t_par_oe = q.t_ad_oe;
        // two-entry write buffer drained by the user side
        if (q.wr_valid && i_wr_ready)
        begin
            d.buf_v[q.rptr] = 1'b0;
            d.rptr = ~q.rptr;
        end
        d.wr_valid = d.buf_v[d.rptr];
        d.wr_data = d.buf_d[d.rptr];
        d.rd_ready = 1'b0;
        case (q.st)
            ST_IDLE:
            begin
                d.claimed_done = 1'b0;
                if (addr_phase && hit)
                begin
                    d.st = ST_DATA;
                    d.write = cmd[0];
                    d.special = (cmd == pha_pkg::CMD_SPECIAL);
                    d.cfg_hit = cmd[3];
                    d.devsel_n = 1'b0;
                    d.ctl_oe = 1'b1;
                    d.stop_n = 1'b1;
                    d.trdy_n = 1'b1;
                end
            end
            ST_DATA:
            begin
                if (xfer)
                begin
                    d.claimed_done = 1'b1;
                    if (q.write)
                    begin
                        d.buf_d[q.wptr] = bus.m_ad;
                        d.buf_v[q.wptr] = 1'b1;
                        d.wptr = ~q.wptr;
                        d.chk_p1 = 1'b1;
                        d.chk_ad = bus.m_ad;
                        d.chk_cbe = bus.m_cbe;
                    end
                    d.trdy_n = 1'b1;
                    d.t_ad_oe = 1'b0;
                    if (bus.m_frame_n)
                        d.st = ST_TURN;
                end
                else if (!q.stop_n && !bus.m_irdy_n && bus.m_frame_n)
                    d.st = ST_TURN;
                else if (q.trdy_n && q.stop_n)
                begin
                    // write: ready only with a free slot
                    if (q.write && !d.buf_v[q.wptr])
                        d.trdy_n = 1'b0;
                    else if (!q.write && i_rd_valid)
                    begin
                        d.t_ad = i_rd_data;
                        d.t_ad_oe = 1'b1;
                        d.trdy_n = 1'b0;
                        d.rd_ready = 1'b1;
                    end
                    else if (q.write)
                        d.stop_n = 1'b0;
                end
            end
            ST_TURN:
            begin
                // drive controls high one clock before release
                d.devsel_n = 1'b1;
                d.trdy_n = 1'b1;
                d.stop_n = 1'b1;
                d.t_ad_oe = 1'b0;
                d.st = ST_BUSY;
            end
            default:
            begin
                d.ctl_oe = 1'b0;
                d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
            q.trdy_n <= 1'b1;
            q.stop_n <= 1'b1;
            q.devsel_n <= 1'b1;
            q.perr_n <= 1'b1;
            q.serr_n <= 1'b1;
        end
        else
            q <= d;
    end

    assign bus.t_ad = q.t_ad;
    assign bus.t_ad_oe = q.t_ad_oe;
    assign bus.t_par = q.t_par;
    assign bus.t_par_oe = q.t_par_oe;
    assign bus.t_trdy_n = q.trdy_n;
    assign bus.t_stop_n = q.stop_n;
    assign bus.t_devsel_n = q.devsel_n;
    assign bus.t_ctl_oe = q.ctl_oe;
    assign bus.t_perr_n = q.perr_n;
    assign bus.t_perr_oe = q.perr_oe;
    assign bus.t_serr_n = q.serr_n;
    assign o_wr_data = q.wr_data;
    assign o_wr_valid = q.wr_valid;
    assign o_rd_ready = q.rd_ready;
    assign o_cfg_hit = q.cfg_hit;
    assign o_par_err = q.par_err;
endmodule // pha_target

/* logic/pha_pkg.sv */
package pha_pkg;
    localparam int DATA_W = 32;
    localparam int CBE_W = 4;
    localparam int PERR_DELAY = 2;
    localparam int RETRY_LIMIT = 16;
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [3:0] CMD_CFG_RD = 4'hA;
    localparam logic [3:0] CMD_CFG_WR = 4'hB;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] BE_ALL = 4'h0;
    localparam logic [31:0] BAR_BASE = 32'h1000_0000;
    localparam int BAR_BITS = 16;

    // even parity over data lines and command/byte-enable lines
    function automatic logic pha_parity(input logic [31:0] ad,
                                        input logic [3:0] cbe);
        pha_parity = ^{ad, cbe};
    endfunction
endpackage

/* logic/pha_bus_if.sv */
// shared bus; pins modelled per driving end, only ad, par, perr and the target controls with enables; controls low-active
interface pha_bus_if;
    // initiator-driven
    logic [31:0] m_ad;
    logic m_ad_oe;
    logic [3:0] m_cbe;
    logic m_par;
    logic m_par_oe;
    logic m_frame_n;
    logic m_irdy_n;
    logic m_req_n;
    logic m_perr_n;
    logic m_perr_oe;
    logic m_serr_n;
    logic m_idsel;
    // target-driven
    logic [31:0] t_ad;
    logic t_ad_oe;
    logic t_par;
    logic t_par_oe;
    logic t_trdy_n;
    logic t_stop_n;
    logic t_devsel_n;
    logic t_ctl_oe;
    logic t_perr_n;
    logic t_perr_oe;
    logic t_serr_n;
    // arbiter
    logic gnt_n;
    modport init (output m_ad, m_ad_oe, m_cbe, m_par, m_par_oe, m_frame_n,
        m_irdy_n, m_req_n, m_perr_n, m_perr_oe, m_serr_n, m_idsel,
        input t_ad, t_ad_oe, t_par, t_par_oe, t_trdy_n, t_stop_n,
        t_devsel_n, t_ctl_oe, t_perr_n, t_perr_oe, t_serr_n, gnt_n);
    modport targ (input m_ad, m_ad_oe, m_cbe, m_par, m_par_oe, m_frame_n,
        m_irdy_n, m_perr_n, m_perr_oe, m_idsel,
        output t_ad, t_ad_oe, t_par, t_par_oe, t_trdy_n, t_stop_n,
        t_devsel_n, t_ctl_oe, t_perr_n, t_perr_oe, t_serr_n);
endinterface

/* logic/pha_initiator.sv */
// bus initiator: request, grant, frame, irdy, read parity check
module pha_initiator (
    input wire logic i_clk,
    input wire logic i_reset,
    pha_bus_if.init bus,
    input wire logic i_start,
    input wire logic i_write,
    input wire logic i_cfg,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_last,
    output logic o_wnext,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output logic o_done,
    output logic o_stopped,
    output logic o_busy
);
    typedef enum logic [2:0] {
        SI_IDLE = 3'b000,
        SI_REQ = 3'b001,
        SI_ADDR = 3'b011,
        SI_DATA = 3'b010,
        SI_END = 3'b110
    } pha_istate_t;

    typedef struct packed {
        pha_istate_t st;
        logic write;
        logic [31:0] ad;
        logic ad_oe;
        logic [3:0] cbe;
        logic par;
        logic par_oe;
        logic frame_n;
        logic irdy_n;
        logic req_n;
        logic idsel;
        logic perr_n;
        logic perr_oe;
        logic serr_n;
        logic chk;
        logic [31:0] chk_ad;
        logic [31:0] rdata;
        logic rvalid;
        logic wnext;
        logic done;
        logic stopped;
        logic busy;
    } pha_iregs_t;

    pha_iregs_t q, d;
    logic xfer;
    logic bad;

    always_comb
    begin
        d = q;
        xfer = (q.st == SI_DATA) && !q.irdy_n && !bus.t_trdy_n;
        d.rvalid = 1'b0;
        d.wnext = 1'b0;
        d.done = 1'b0;
        d.stopped = 1'b0;
        d.serr_n = 1'b1;
        d.par = pha_pkg::pha_parity(q.ad, q.cbe);
        d.par_oe = q.ad_oe;
        // read parity checked a clock after data; perr driven at once
        d.chk = 1'b0;
        bad = q.chk && bus.t_par_oe
            && (pha_pkg::pha_parity(q.chk_ad, pha_pkg::BE_ALL) != bus.t_par);
        if (bad)
        begin
            d.perr_n = 1'b0;
            d.perr_oe = 1'b1;
        end
        else if (q.perr_oe && !q.perr_n)
            d.perr_n = 1'b1;
        else
            d.perr_oe = 1'b0;
        case (q.st)
            SI_IDLE:
                if (i_start)
                begin
                    d.st = SI_REQ;
                    d.req_n = 1'b0;
                    d.write = i_write;
                    d.ad = i_addr;
                    d.cbe = i_cfg ? {pha_pkg::CMD_CFG_RD[3:1], i_write}
                        : {pha_pkg::CMD_MEM_RD[3:1], i_write};
                    d.idsel = i_cfg;
                    d.busy = 1'b1;
                end
            SI_REQ:
                if (!bus.gnt_n)
                begin
                    d.st = SI_ADDR;
                    d.frame_n = 1'b0;
                    d.ad_oe = 1'b1;
                    d.req_n = 1'b1;
                end
            SI_ADDR:
            begin
                d.st = SI_DATA;
                d.cbe = pha_pkg::BE_ALL;
                d.idsel = 1'b0;
                d.ad = i_wdata;
                d.ad_oe = q.write;
                d.irdy_n = 1'b0;
                d.wnext = q.write;
                d.frame_n = i_last;
            end
            SI_DATA:
                if (xfer)
                begin
                    if (!q.write)
                    begin
                        d.rdata = bus.t_ad;
                        d.rvalid = 1'b1;
                        d.chk = 1'b1;
                        d.chk_ad = bus.t_ad;
                    end
                    if (q.frame_n)
                    begin
                        // irdy must not linger after the final phase
                        d.irdy_n = 1'b1;
                        d.ad_oe = 1'b0;
                        d.st = SI_END;
                    end
                    else
                    begin
                        d.ad = i_wdata;
                        d.wnext = q.write;
                        d.frame_n = i_last;
                    end
                end
                else if (!bus.t_stop_n)
                begin
                    // frame rises now, irdy follows one clock later
                    d.frame_n = 1'b1;
                    d.stopped = 1'b1;
                    d.st = SI_END;
                end
                else
                    d.ad = q.ad;
            default:
            begin
                d.irdy_n = 1'b1;
                d.frame_n = 1'b1;
                d.ad_oe = 1'b0;
                d.done = 1'b1;
                d.busy = 1'b0;
                d.st = SI_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
            q.frame_n <= 1'b1;
            q.irdy_n <= 1'b1;
            q.req_n <= 1'b1;
            q.perr_n <= 1'b1;
            q.serr_n <= 1'b1;
        end
        else
            q <= d;
    end

    assign bus.m_ad = q.ad;
    assign bus.m_ad_oe = q.ad_oe;
    assign bus.m_cbe = q.cbe;
    assign bus.m_par = q.par;
    assign bus.m_par_oe = q.par_oe;
    assign bus.m_frame_n = q.frame_n;
    assign bus.m_irdy_n = q.irdy_n;
    assign bus.m_req_n = q.req_n;
    assign bus.m_idsel = q.idsel;
    assign bus.m_perr_n = q.perr_n;
    assign bus.m_perr_oe = q.perr_oe;
    assign bus.m_serr_n = q.serr_n;
    assign o_rdata = q.rdata;
    assign o_rvalid = q.rvalid;
    assign o_wnext = q.wnext;
    assign o_done = q.done;
    assign o_stopped = q.stopped;
    assign o_busy = q.busy;
endmodule // pha_initiator

/* sim/pha_checker.sv */
// wire rules of the joined pair; parity reports on the hand-driven bus
module pha_checker (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic [31:0] m_ad,
    input wire logic m_ad_oe,
    input wire logic [3:0] m_cbe,
    input wire logic m_par,
    input wire logic m_frame_n,
    input wire logic m_irdy_n,
    input wire logic m_req_n,
    input wire logic gnt_n,
    input wire logic t_ad_oe,
    input wire logic t_trdy_n,
    input wire logic t_stop_n,
    input wire logic t_devsel_n,
    input wire logic t_perr_n,
    input wire logic t_perr_oe,
    input wire logic [31:0] b_ad,
    input wire logic b_ad_oe,
    input wire logic [3:0] b_cbe,
    input wire logic b_par,
    input wire logic b_irdy_n,
    input wire logic b_trdy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic par_q;
    logic xfer;
    logic mem_hit;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // parity due one clock after the lines it covers
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            par_q <= 1'h0;
        else
            par_q <= ^{b_ad, b_cbe};
    end

    // completed phase on the faulted bus; address inside the memory window
    assign xfer = !b_irdy_n && !b_trdy_n;
    assign mem_hit = m_ad[31:16] == pha_pkg::BAR_BASE[31:16] &&
        (m_cbe == pha_pkg::CMD_MEM_RD || m_cbe == pha_pkg::CMD_MEM_WR);

    sequence s_bad_wr;
        xfer && b_ad_oe ##1 b_par != par_q;
    endsequence
    sequence s_perr_end;
        !t_perr_n ##1 t_perr_n;
    endsequence

    property p_req_hold;
        !m_req_n && gnt_n |=> !m_req_n;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before grant");
    property p_grant;
        $fell(m_frame_n) |-> !$past(gnt_n);
    endproperty
    a_grant: assert property (p_grant)
        else $error("frame started without grant");
    property p_claim;
        $fell(m_frame_n) && mem_hit |=> !t_devsel_n;
    endproperty
    a_claim: assert property (p_claim)
        else $error("own address not claimed next clock");
    property p_wait;
        !m_irdy_n && t_trdy_n && t_stop_n |=> !m_irdy_n;
    endproperty
    a_wait: assert property (p_wait)
        else $error("initiator ready dropped in wait state");
    property p_rd_valid;
        !t_trdy_n && !m_ad_oe |-> t_ad_oe;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read ready without read data driven");
    property p_last;
        $rose(m_frame_n) |-> !m_irdy_n;
    endproperty
    a_last: assert property (p_last)
        else $error("frame ended outside a data phase");
    property p_stop;
        !t_stop_n && !m_frame_n |-> ##[1:2] m_frame_n;
    endproperty
    a_stop: assert property (p_stop)
        else $error("initiator ignored target stop");
    property p_perr_drive;
        s_perr_end |-> t_perr_oe;
    endproperty
    a_perr_drive: assert property (p_perr_drive)
        else $error("parity error released without high clock");
    property p_perr_late;
        s_bad_wr |=> !t_perr_n;
    endproperty
    a_perr_late: assert property (p_perr_late)
        else $error("parity error not two clocks after data");
endmodule // pha_checker

/* sim/pci_handshake_arbitration_errors_tb_top.sv */
module pci_handshake_arbitration_errors_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BAR = pha_pkg::BAR_BASE;
    logic i_clk = 1'h0;
    logic i_reset = 1'h1;
    logic i_start = 1'h0;
    logic i_write = 1'h0;
    logic i_cfg = 1'h0;
    logic [31:0] i_addr = 32'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_last = 1'h0;
    logic i_wr_ready = 1'h0;
    logic [31:0] i_rd_data = 32'h0;
    logic i_rd_valid = 1'h0;
    logic o_wnext, o_rvalid, o_done, o_stopped, o_busy;
    logic [31:0] o_rdata, o_wr_data;
    logic o_wr_valid, o_rd_ready, o_cfg_hit, o_par_err;
    logic stall = 1'h0;
    logic cfg_on = 1'h0;
    logic hit_seen = 1'h0;
    int fails = 0;
    int n_compared = 0;
    int n_stop = 0;
    int serr_cnt = 0;
    logic [31:0] wq[$];
    logic [31:0] rq[$];
    pha_bus_if bus();
    pha_bus_if b2();

    pha_initiator pha_initiator_i (.i_clk, .i_reset, .bus(bus), .i_start,
        .i_write, .i_cfg, .i_addr, .i_wdata, .i_last, .o_wnext, .o_rdata,
        .o_rvalid, .o_done, .o_stopped, .o_busy);
    pha_target pha_target_i (.i_clk, .i_reset, .bus(bus), .o_wr_data,
        .o_wr_valid, .i_wr_ready, .i_rd_data, .i_rd_valid, .o_rd_ready,
        .o_cfg_hit, .o_par_err);
    // second target faces a hand-driven bus; its user side only sinks
    pha_target pha_target_i2 (.i_clk, .i_reset, .bus(b2), .o_wr_data(),
        .o_wr_valid(), .i_wr_ready(1'h1), .i_rd_data(32'h0),
        .i_rd_valid(1'h0), .o_rd_ready(), .o_cfg_hit(), .o_par_err());
    pha_checker pha_checker_i (.i_clk, .i_reset, .m_ad(bus.m_ad),
        .m_ad_oe(bus.m_ad_oe), .m_cbe(bus.m_cbe), .m_par(bus.m_par),
        .m_frame_n(bus.m_frame_n), .m_irdy_n(bus.m_irdy_n),
        .m_req_n(bus.m_req_n), .gnt_n(bus.gnt_n), .t_ad_oe(bus.t_ad_oe),
        .t_trdy_n(bus.t_trdy_n), .t_stop_n(bus.t_stop_n),
        .t_devsel_n(bus.t_devsel_n), .t_perr_n(b2.t_perr_n),
        .t_perr_oe(b2.t_perr_oe), .b_ad(b2.m_ad), .b_ad_oe(b2.m_ad_oe),
        .b_cbe(b2.m_cbe), .b_par(b2.m_par), .b_irdy_n(b2.m_irdy_n),
        .b_trdy_n(b2.t_trdy_n));

    // 40 MHz
    always #12.5 i_clk = ~i_clk;

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // arbiter with random grant delay; user side stalls at random
    always @(posedge i_clk)
    begin
        bus.gnt_n <= bus.m_req_n | ($urandom_range(2) == 0);
        i_wr_ready <= !stall && $urandom_range(3) != 0;
        if (i_rd_valid && o_rd_ready)
        begin
            rq.push_back(i_rd_data);
            i_rd_data <= $urandom;
        end
        if (!i_rd_valid || o_rd_ready)
            i_rd_valid <= 1'($urandom_range(1));
        if (o_cfg_hit)
            hit_seen <= 1'h1;
        if (!b2.t_serr_n)
            serr_cnt++;
    end

    // results taken in the order they were noted
    always @(posedge i_clk)
    begin
        if (o_wr_valid && i_wr_ready)
            check("wr_data", o_wr_data, wq.pop_front());
        if (o_rvalid && !cfg_on)
            check("rdata", o_rdata, rq.pop_front());
        if (o_par_err)
            check("par_err", 32'h1, 32'h0);
    end

    // one request, resumed from the stopped word after a target stop
    task automatic xact(input logic wr, input logic cf, input int n);
        logic [31:0] w[$];
        int k;
        int t;
        k = 0;
        repeat (n) w.push_back($urandom);
        while (k < n)
        begin
            @(posedge i_clk);
            i_start <= 1'h1;
            i_write <= wr;
            i_cfg <= cf;
            i_addr <= cf ? 32'h10 : BAR + 32'(k) * 32'h4;
            i_wdata <= w[k];
            i_last <= k == n - 1;
            @(posedge i_clk);
            i_start <= 1'h0;
            t = 0;
            do
            begin
                @(posedge i_clk);
                t++;
                if (o_wnext && wr)
                    wq.push_back(w[k]);
                if (o_wnext || (!wr && o_rvalid))
                    k++;
                i_wdata <= w[k % n];
                i_last <= k >= n - 1;
            end
            while (t < 300 && !o_done && !o_stopped);
            check("xact_end", 32'(o_done || o_stopped), 32'h1);
            if (wr && o_done)
                check("words", 32'(k), 32'(n));
            n_stop += 32'(o_stopped);
            if (o_stopped && wr)
            begin
                // the refused phase carried the last noted word
                void'(wq.pop_back());
                k--;
            end
            stall <= 1'h0; // lifted once the full buffer has refused
            if (!o_stopped)
                k = n;
            while (o_busy && t++ < 600)
                @(posedge i_clk);
        end
    endtask

    // hand-driven single write phase, parity faults on demand
    task automatic raw(input logic [3:0] cmd, input logic sel,
        input logic [31:0] a, input logic apar, input logic dpar,
        input logic claim);
        int t;
        int s;
        logic [31:0] d;
        d = $urandom;
        s = serr_cnt;
        @(posedge i_clk);
        b2.m_frame_n <= 1'h0;
        b2.m_ad_oe <= 1'h1;
        b2.m_ad <= a;
        b2.m_cbe <= cmd;
        b2.m_idsel <= sel;
        @(posedge i_clk);
        b2.m_par <= ^{a, cmd} ^ apar;
        b2.m_par_oe <= 1'h1;
        b2.m_frame_n <= 1'h1;
        b2.m_irdy_n <= 1'h0;
        b2.m_ad <= d;
        b2.m_cbe <= pha_pkg::BE_ALL;
        t = 0;
        do
        begin
            @(posedge i_clk);
            t++;
        end
        while (b2.t_trdy_n && t < 6);
        if (!apar)
            check("claim", 32'(!b2.t_trdy_n), 32'(claim));
        b2.m_irdy_n <= 1'h1;
        b2.m_ad_oe <= 1'h0;
        b2.m_ad <= ~d;
        b2.m_par <= ^{d, pha_pkg::BE_ALL} ^ dpar;
        @(posedge i_clk);
        b2.m_par_oe <= 1'h0;
        b2.m_par <= ~b2.m_par;
        @(posedge i_clk);
        check("perr_low", 32'(!b2.t_perr_n), 32'(dpar && claim));
        @(posedge i_clk);
        check("perr_high", 32'(b2.t_perr_n && b2.t_perr_oe),
            32'(dpar && claim));
        @(posedge i_clk);
        check("perr_oe", 32'(b2.t_perr_oe), 32'h0);
        check("serr", 32'(serr_cnt - s), 32'(apar));
    endtask

    // main sequence
    initial
    begin
        void'($urandom(32'h6412));
        b2.m_frame_n = 1'h1;
        b2.m_irdy_n = 1'h1;
        b2.m_ad_oe = 1'h0;
        b2.m_par_oe = 1'h0;
        b2.m_idsel = 1'h0;
        b2.m_ad = 32'h0;
        b2.m_cbe = 4'h0;
        b2.m_par = 1'h0;
        b2.m_perr_n = 1'h1;
        b2.m_perr_oe = 1'h0;
        repeat (4) @(posedge i_clk);
        i_reset <= 1'h0;
        @(posedge i_clk);
        xact(1'h1, 1'h0, 4);
        stall <= 1'h1;
        xact(1'h1, 1'h0, 6);
        check("stopped", 32'(n_stop > 0), 32'h1);
        repeat (4) xact(1'h0, 1'h0, 1);
        check("mem_cfg_hit", 32'(hit_seen), 32'h0);
        cfg_on <= 1'h1;
        xact(1'h0, 1'h1, 1);
        check("cfg_hit", 32'(hit_seen), 32'h1);
        cfg_on <= 1'h0;
        rq.delete();
        raw(pha_pkg::CMD_MEM_WR, 1'h0, BAR, 1'h0, 1'h0, 1'h1);
        raw(pha_pkg::CMD_MEM_WR, 1'h0, BAR, 1'h0, 1'h1, 1'h1);
        raw(pha_pkg::CMD_CFG_WR, 1'h1, 32'h10, 1'h0, 1'h0, 1'h1);
        raw(pha_pkg::CMD_CFG_WR, 1'h0, 32'h10, 1'h0, 1'h0, 1'h0);
        raw(pha_pkg::CMD_MEM_WR, 1'h0, 32'h2000_0000, 1'h0, 1'h0, 1'h0);
        raw(pha_pkg::CMD_SPECIAL, 1'h0, 32'h0, 1'h0, 1'h1, 1'h0);
        raw(pha_pkg::CMD_MEM_WR, 1'h0, BAR, 1'h1, 1'h0, 1'h1);
        repeat (8) @(posedge i_clk);
        check("wq_left", 32'(wq.size()), 32'h0);
        report_and_stop();
    end

    // hang guard; the sequence needs well under a few thousand clocks
    initial
    begin
        repeat (20000) @(posedge i_clk);
        fails++;
        report_and_stop();
    end
endmodule // pci_handshake_arbitration_errors_tb_top
